// >>> logic/cpu_change_protect_pkg.sv
// Purpose: Shared constants and types for the CPU change protection register group
// Assumes: Registers reached over AXI4-Lite, one 32-bit word per register index
// Notes: Byte address of a register is four times its index
package cpu_change_protect_pkg;

    // Register indices, byte address is index times four
    localparam logic [5:0] IDX_KEY = 6'h04; // Change unlock key
    localparam logic [5:0] IDX_SPL = 6'h0D; // Stack pointer low byte
    localparam logic [5:0] IDX_SPH = 6'h0E; // Stack pointer high byte
    localparam logic [5:0] IDX_FLAGS = 6'h0F; // Status flags

    // Key signatures and reset values
    localparam logic [7:0] KEY_IO = 8'hD8; // Opens io_unlock window
    localparam logic [7:0] KEY_SPM = 8'h9D; // Opens self_program_unlock window
    localparam logic [7:0] KEY_RESET = 8'h00; // Key register reset value
    localparam logic [7:0] FLAGS_RESET = 8'h00; // Status flags reset value

    // Instruction counts
    localparam logic [2:0] WINDOW_INSTRS = 3'h4; // Unlock window length
    localparam logic [2:0] SP_BLOCK_INSTRS = 3'h4; // Interrupt hold after low byte write

    // Field positions
    localparam int KEY_IO_BIT = 0; // Key readback, I/O window active
    localparam int KEY_SPM_BIT = 1; // Key readback, self-program window active
    localparam int FLAG_I = 7; // Global interrupt enable
    localparam int FLAG_T = 6; // Bit copy storage
    localparam int FLAG_S = 4; // Sign
    localparam int FLAG_V = 3; // Overflow
    localparam int FLAG_N = 2; // Negative

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0; // Mapped access
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped access

    // CPU execution events, one-cycle pulses
    typedef struct packed {
        logic retire; // One instruction retired
        logic memWrite; // CPU wrote I/O or data memory
        logic nvmAccess; // Load or store to Flash, controller or EEPROM
        logic sleepExec; // Sleep instruction executed
    } cpu_event_type;

    // ALU flag update from the core
    typedef struct packed {
        logic valid; // Apply this update
        logic [7:0] mask; // Flags the instruction affects
        logic [7:0] value; // New flag values
    } flag_update_type;

    // Single-bit flag instructions
    typedef struct packed {
        logic bitStore; // bit_store_instr
        logic storeBit; // Bit copied into bit copy flag
        logic intrSet; // interrupt_set_instr
        logic intrClear; // interrupt_clear_instr
    } bit_op_type;

    // Write channel state
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_WAIT = 3'b010,
        WR_RESP = 3'b100
    } wr_state_type;

endpackage

// >>> logic/cpu_change_protect_regs.sv
// Purpose: CPU change protection key, stack pointer and status flags register group
// Assumes: CPU events are synchronous pulses on clk_sys; AXI4-Lite master as recalled
// Notes: Byte lane 0 carries register data; upper data bits read zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module cpu_change_protect_regs
    import cpu_change_protect_pkg::*;
#(
    parameter int SP_WIDTH = 16, // Implemented stack pointer bits, up to 16
    parameter logic [15:0] SRAM_TOP = 16'h3FFF // Highest internal SRAM address
)(
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire cpu_event_type cpuEvent, // Core execution events
    input wire flag_update_type flagUpdate, // ALU flag results
    input wire bit_op_type bitOp, // Flag bit instructions
    output logic ioUnlock, // Protected I/O writes accepted
    output logic selfProgramUnlock, // Controller command write permitted
    output logic irqEnable, // Interrupts may be serviced now
    output logic bitLoadValue, // Source bit for bit_load_instr
    output logic [15:0] stackPointer, // Current stack pointer
    output logic [7:0] statusFlags // Current status flags
);

    // Keep unimplemented stack pointer bits at zero
    function automatic logic [15:0] maskSp(input logic [15:0] value);
        logic [15:0] mask;
        mask = 16'hFFFF >> (16 - SP_WIDTH);
        return value & mask;
    endfunction

    localparam logic [15:0] SP_RESET = maskSp(SRAM_TOP); // Top of SRAM, masked

    // Write channel registers
    wr_state_type wrState_reg; // Write channel state
    wr_state_type wrState_next; // Next write state
    logic awTaken_reg; // Address captured
    logic [5:0] awIdx_reg; // Captured register index
    logic awMap_reg; // Captured address is word aligned
    logic wTaken_reg; // Data captured
    logic [7:0] wData_reg; // Captured low data byte
    logic wStrb_reg; // Captured lane 0 strobe
    logic [1:0] bResp_reg; // Write response code

    // Read channel registers
    logic rValid_reg; // Read data pending
    logic [7:0] rData_reg; // Read data byte
    logic [1:0] rResp_reg; // Read response code

    // Block state
    logic ioWin_reg; // I/O unlock window open
    logic spmWin_reg; // Self-program unlock window open
    logic [2:0] winCount_reg; // Instructions left in window
    logic [2:0] spCount_reg; // Instructions left in stack pointer hold
    logic [15:0] sp_reg; // Stack pointer
    logic [7:0] spTemp_reg; // Shared 16-bit access temporary
    logic [7:0] flags_reg; // Status flags
    logic [7:0] flags_next; // Next status flags

    // Write decode
    wire doWrite = (wrState_reg == WR_IDLE) && awTaken_reg && wTaken_reg; // Commit cycle
    wire wrLane = doWrite && wStrb_reg && awMap_reg; // Byte lane written
    wire wrKey = wrLane && (awIdx_reg == IDX_KEY); // Key write
    wire wrSpl = wrLane && (awIdx_reg == IDX_SPL); // Stack pointer low write
    wire wrSph = wrLane && (awIdx_reg == IDX_SPH); // Stack pointer high write
    wire wrFlags = wrLane && (awIdx_reg == IDX_FLAGS); // Status write
    wire wrHit = awMap_reg && ((awIdx_reg == IDX_KEY) || (awIdx_reg == IDX_SPL)
                 || (awIdx_reg == IDX_SPH) || (awIdx_reg == IDX_FLAGS)); // Mapped target
    wire keyIo = wrKey && (wData_reg == KEY_IO);
    wire keySpm = wrKey && (wData_reg == KEY_SPM);
    wire keyAny = keyIo || keySpm; // Window reopened this cycle
    wire iChange = wrFlags && (wData_reg[FLAG_I] != flags_reg[FLAG_I]);

    // Read decode
    wire rdTake = s_axi_arvalid && s_axi_arready; // Read address accepted
    wire [5:0] arIdx = s_axi_araddr[7:2]; // Read register index
    wire arMap = (s_axi_araddr[1:0] == 2'h0); // Word aligned
    wire rdSpl = rdTake && arMap && (arIdx == IDX_SPL); // Low byte read latches high
    wire [7:0] keyRead = {6'h00, spmWin_reg, ioWin_reg};
    wire [7:0] spRead = stackPointer[7:0];
    wire [7:0] rdMux = !arMap ? 8'h00 :
                       (arIdx == IDX_KEY) ? keyRead :
                       (arIdx == IDX_SPL) ? spRead :
                       (arIdx == IDX_SPH) ? spTemp_reg :
                       (arIdx == IDX_FLAGS) ? flags_reg : 8'h00; // Read selection
    wire rdHit = arMap && ((arIdx == IDX_KEY) || (arIdx == IDX_SPL) || (arIdx == IDX_SPH)
                 || (arIdx == IDX_FLAGS)); // Mapped read

    // Window cancel and expiry
    wire cancelIo = cpuEvent.memWrite || cpuEvent.nvmAccess || cpuEvent.sleepExec
                    || (doWrite && !wrKey);
    wire cancelSpm = cpuEvent.nvmAccess || cpuEvent.sleepExec;
    wire expire = cpuEvent.retire && (winCount_reg == 3'h1);
    wire spHoldEnd = cpuEvent.memWrite || (doWrite && !wrSpl);

    // Handshake outputs
    assign s_axi_awready = (wrState_reg == WR_IDLE) && !awTaken_reg;
    assign s_axi_wready = (wrState_reg == WR_IDLE) && !wTaken_reg;
    assign s_axi_bvalid = (wrState_reg == WR_RESP);
    assign s_axi_bresp = bResp_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = {24'h00_0000, rData_reg};
    assign s_axi_rresp = rResp_reg;

    // Block outputs; interrupts wait while any window or hold is active
    assign ioUnlock = ioWin_reg;
    assign selfProgramUnlock = spmWin_reg;
    assign irqEnable = flags_reg[FLAG_I] && !ioWin_reg && !spmWin_reg
                       && (spCount_reg == 3'h0);
    assign bitLoadValue = flags_reg[FLAG_T];
    assign stackPointer = maskSp(sp_reg);
    assign statusFlags = flags_reg;

    // Write state sequencing; an enable change costs one extra cycle
    always_comb
    begin
        wrState_next = wrState_reg;
        case (wrState_reg)
            WR_IDLE: if (doWrite) wrState_next = iChange ? WR_WAIT : WR_RESP;
            WR_WAIT: wrState_next = WR_RESP;
            WR_RESP: if (s_axi_bready) wrState_next = WR_IDLE;
            default: wrState_next = WR_IDLE;
        endcase
    end

    // Write channel capture; address and data may arrive in either order
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wrState_reg <= WR_IDLE;
            awTaken_reg <= 1'b0;
            awIdx_reg <= 6'h00;
            awMap_reg <= 1'b0;
            wTaken_reg <= 1'b0;
            wData_reg <= 8'h00;
            wStrb_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
        end
        else
        begin
            wrState_reg <= wrState_next;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awTaken_reg <= 1'b1;
                awIdx_reg <= s_axi_awaddr[7:2];
                awMap_reg <= (s_axi_awaddr[1:0] == 2'h0);
            end
            else if (doWrite)
                awTaken_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wTaken_reg <= 1'b1;
                wData_reg <= s_axi_wdata[7:0];
                wStrb_reg <= s_axi_wstrb[0];
            end
            else if (doWrite)
                wTaken_reg <= 1'b0;
            if (doWrite)
                bResp_reg <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Read channel; answer one cycle after the address is taken
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rValid_reg <= 1'b0;
            rData_reg <= 8'h00;
            rResp_reg <= RESP_OKAY;
        end
        else if (rdTake)
        begin
            rValid_reg <= 1'b1;
            rData_reg <= rdMux;
            rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rValid_reg <= 1'b0;
    end

    // Unlock windows; a new key write wins over any cancel in the same cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ioWin_reg <= 1'b0;
            spmWin_reg <= 1'b0;
            winCount_reg <= 3'h0;
        end
        else if (keyIo)
        begin
            ioWin_reg <= 1'b1;
            spmWin_reg <= 1'b0;
            winCount_reg <= WINDOW_INSTRS;
        end
        else if (keySpm)
        begin
            spmWin_reg <= 1'b1;
            ioWin_reg <= 1'b0;
            winCount_reg <= WINDOW_INSTRS;
        end
        else
        begin
            if (cancelIo || expire)
                ioWin_reg <= 1'b0;
            if (cancelSpm || expire)
                spmWin_reg <= 1'b0;
            if (cpuEvent.retire && (winCount_reg != 3'h0))
                winCount_reg <= winCount_reg - 3'h1;
        end
    end

    // Stack pointer and its shared temporary
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sp_reg <= SP_RESET;
            spTemp_reg <= 8'h00;
            spCount_reg <= 3'h0;
        end
        else
        begin
            if (wrSpl)
                spTemp_reg <= wData_reg;
            else if (rdSpl)
                spTemp_reg <= stackPointer[15:8];
            if (wrSph)
                sp_reg <= maskSp({wData_reg, spTemp_reg});
            if (wrSpl)
                spCount_reg <= SP_BLOCK_INSTRS;
            else if (spHoldEnd)
                spCount_reg <= 3'h0;
            else if (cpuEvent.retire && (spCount_reg != 3'h0))
                spCount_reg <= spCount_reg - 3'h1;
        end
    end

    // Status flags; a register write overrides same-cycle core updates
    always_comb
    begin
        flags_next = flags_reg;
        if (flagUpdate.valid)
            flags_next = (flags_reg & ~flagUpdate.mask) | (flagUpdate.value & flagUpdate.mask);
        if (bitOp.bitStore)
            flags_next[FLAG_T] = bitOp.storeBit;
        if (bitOp.intrSet)
            flags_next[FLAG_I] = 1'b1;
        if (bitOp.intrClear)
            flags_next[FLAG_I] = 1'b0;
        if (wrFlags)
            flags_next = wData_reg;
        flags_next[FLAG_S] = flags_next[FLAG_N] ^ flags_next[FLAG_V];
    end

    // Flags register; nothing clears the enable on interrupt entry
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            flags_reg <= FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_key_io;
        keyIo |=> ioWin_reg && !spmWin_reg;
    endproperty
    a_key_io: assert property (p_key_io) else $error("I/O key did not open window");

    property p_key_spm;
        keySpm |=> spmWin_reg && !ioWin_reg;
    endproperty
    a_key_spm: assert property (p_key_spm) else $error("SELF_PROGRAM_UNLOCK key did not open window");

    property p_expire;
        (expire && !keyAny) |=> !ioWin_reg && !spmWin_reg && (winCount_reg == 3'h0);
    endproperty
    a_expire: assert property (p_expire) else $error("Window outlived four instructions");

    property p_io_cancel;
        (ioWin_reg && cancelIo && !keyAny) |=> !ioWin_reg;
    endproperty
    a_io_cancel: assert property (p_io_cancel) else $error("I/O window not cancelled");

    property p_spm_cancel;
        (spmWin_reg && cancelSpm && !keyAny) |=> !spmWin_reg;
    endproperty
    a_spm_cancel: assert property (p_spm_cancel) else $error("SELF_PROGRAM_UNLOCK window not cancelled");

    property p_irq_blocked;
        (ioWin_reg || spmWin_reg) |-> !irqEnable;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked) else $error("Interrupt open in window");

    property p_irq_resume;
        (flags_reg[FLAG_I] && !ioWin_reg && !spmWin_reg && spCount_reg == 3'h0) |-> irqEnable;
    endproperty
    a_irq_resume: assert property (p_irq_resume) else $error("Interrupts not resumed");

    property p_key_read;
        (rdTake && arMap && arIdx == IDX_KEY) |=>
            s_axi_rvalid && (s_axi_rdata[7:2] == 6'h00)
            && (s_axi_rdata[0] == $past(ioWin_reg)) && (s_axi_rdata[1] == $past(spmWin_reg));
    endproperty
    a_key_read: assert property (p_key_read) else $error("Key readback wrong");

    property p_sign;
        statusFlags[FLAG_S] == (statusFlags[FLAG_N] ^ statusFlags[FLAG_V]);
    endproperty
    a_sign: assert property (p_sign) else $error("Sign flag mismatch");

    property p_sp_hold;
        (wrSpl && !cpuEvent.retire) ##1 (!cpuEvent.retire && !spHoldEnd && !wrSpl)
            |=> !irqEnable && (spCount_reg == SP_BLOCK_INSTRS);
    endproperty
    a_sp_hold: assert property (p_sp_hold) else $error("Stack pointer hold lost");

    sequence s_enable_write;
        doWrite && iChange;
    endsequence
    sequence s_wait_then_resp;
        (wrState_reg == WR_WAIT) && !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wait_state;
        s_enable_write |=> s_wait_then_resp;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("No wait cycle on enable");

    property p_sp_commit;
        wrSph |=> stackPointer == maskSp({$past(wData_reg), $past(spTemp_reg)});
    endproperty
    a_sp_commit: assert property (p_sp_commit) else $error("Stack pointer commit wrong");

endmodule // cpu_change_protect_regs

// >>> tb/cpu_core_model.sv
// Purpose: Behavioural CPU core that retires instructions and reports memory events
// Assumes: The bench asks for one instruction per opValid pulse
// Notes: Every event kind also retires the instruction that caused it
`timescale 1ns/100ps
module cpu_core_model
    import cpu_change_protect_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic opValid, // Execute one instruction
    input wire logic [1:0] opKind, // 0 plain, 1 memory write, 2 nonvolatile access, 3 sleep
    output cpu_event_type cpuEvent // Execution events, one-cycle pulses
);
    // Report one cycle late, as a pipelined core would; pulses never stretch
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cpuEvent <= '0; // Quiet core during reset
        end
        else
        begin
            cpuEvent.retire <= opValid;
            cpuEvent.memWrite <= opValid && (opKind == 2'h1);
            cpuEvent.nvmAccess <= opValid && (opKind == 2'h2);
            cpuEvent.sleepExec <= opValid && (opKind == 2'h3);
        end
    end
endmodule // cpu_core_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the change protection register group
// Assumes: AXI4-Lite master tasks; core events come from cpu_core_model
// Notes: Stack pointer built 14 bits wide so unimplemented bits are visible
`timescale 1ns/100ps
module testbench
    import cpu_change_protect_pkg::*;
;
    localparam int SPW = 14; // Narrow stack pointer build
    localparam logic [15:0] TOP = 16'h3FFF; // Highest SRAM address of this build
    localparam int CEIL = 20000; // Cycle ceiling; the tests need a few hundred
    localparam logic [7:0] A_KEY = {IDX_KEY, 2'b00}; // Key byte address
    localparam logic [7:0] A_SPL = {IDX_SPL, 2'b00}; // Stack pointer low
    localparam logic [7:0] A_SPH = {IDX_SPH, 2'b00}; // Stack pointer high
    localparam logic [7:0] A_FLG = {IDX_FLAGS, 2'b00}; // Status flags
    logic clk_sys, nrst; // Clock and reset
    logic [7:0] s_axi_awaddr, s_axi_araddr; // Bus addresses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write handshakes
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // Response and read
    logic s_axi_rvalid, s_axi_rready; // Read data handshake
    logic [31:0] s_axi_wdata, s_axi_rdata; // Bus data
    logic [3:0] s_axi_wstrb; // Byte strobes
    logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
    logic opValid; // Core instruction request
    logic [1:0] opKind; // Core instruction kind
    cpu_event_type cpuEvent; // Core events
    flag_update_type flagUpdate; // ALU results
    bit_op_type bitOp; // Flag bit instructions
    logic ioUnlock, selfProgramUnlock, irqEnable, bitLoadValue; // Status outputs
    logic [15:0] stackPointer; // Stack pointer output
    logic [7:0] statusFlags; // Flags output
    int miscompares = 0; // Mismatch count
    int comparisons = 0; // Comparison count
    int cycles = 0; // Hang guard

    cpu_change_protect_regs #(.SP_WIDTH(SPW), .SRAM_TOP(TOP)) cpu_change_protect_regs_i (
        .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cpuEvent(cpuEvent), .flagUpdate(flagUpdate),
        .bitOp(bitOp), .ioUnlock(ioUnlock), .selfProgramUnlock(selfProgramUnlock),
        .irqEnable(irqEnable), .bitLoadValue(bitLoadValue), .stackPointer(stackPointer),
        .statusFlags(statusFlags));
    cpu_core_model cpu_core_model_i (.clk_sys(clk_sys), .nrst(nrst), .opValid(opValid),
        .opKind(opKind), .cpuEvent(cpuEvent));

    // Verdict and end of run, shared by the main sequence and the hang guard
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Four-state compare so an unknown never passes
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Ready is sampled at the falling edge, where it has settled, and acted on at the rise
    task automatic expectWrite(input logic [7:0] addr, input logic [7:0] data, input int expLat,
        input logic [1:0] expResp, input string what);
        logic a, w, b;
        logic [1:0] resp;
        int lat;
        @(posedge clk_sys);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, data};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        lat = 0;
        b = 1'b0;
        while (!b)
        begin
            @(negedge clk_sys);
            a = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            lat++;
            if (a)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check(lat, expLat, what);
        check(resp, expResp, what);
        @(negedge clk_sys);
    endtask

    // Read one register; rready stays up until rvalid is seen
    task automatic expectRead(input logic [7:0] addr, input logic [31:0] exp,
        input logic [1:0] expResp, input string what);
        logic a, r;
        logic [31:0] data;
        logic [1:0] resp;
        @(posedge clk_sys);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            @(negedge clk_sys);
            a = s_axi_arready;
            r = s_axi_rvalid;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (a)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check(data, exp, what);
        check(resp, expResp, what);
    endtask

    // One core instruction; returns once the block has reacted
    task automatic cpuOp(input logic [1:0] kind);
        @(posedge clk_sys);
        opValid <= 1'b1;
        opKind <= kind;
        @(posedge clk_sys);
        opValid <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // One-cycle flag instruction pulses
    task automatic pulseFlags(input flag_update_type fu, input bit_op_type bo);
        @(posedge clk_sys);
        flagUpdate <= fu;
        bitOp <= bo;
        @(posedge clk_sys);
        flagUpdate <= '0;
        bitOp <= '0;
        @(negedge clk_sys);
    endtask

    // Free-running clock, 5 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            miscompares++;
            $display("mismatch at %0t: run did not finish in time", $time);
            results();
        end
    end

    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, opValid, opKind} = '0;
        s_axi_wstrb = 4'h1;
        flagUpdate = '0;
        bitOp = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        // Reset state and map
        check(irqEnable, 1'b0, "irq after reset");
        expectRead(A_KEY, 32'h0000_0000, RESP_OKAY, "key reset");
        expectRead(A_FLG, 32'h0000_0000, RESP_OKAY, "flags reset");
        expectRead(A_SPL, 32'h0000_00FF, RESP_OKAY, "sp low reset");
        expectRead(A_SPH, 32'h0000_003F, RESP_OKAY, "sp high reset");
        expectRead(8'h14, 32'h0000_0000, RESP_SLVERR, "unmapped read");
        expectWrite(8'h08, 8'h55, 3, RESP_SLVERR, "unmapped write");
        $display("test reset and map done");
        // Global enable and its wait state
        expectWrite(A_FLG, 8'h80, 4, RESP_OKAY, "enable write");
        check(irqEnable, 1'b1, "irq enabled");
        expectWrite(A_FLG, 8'h80, 3, RESP_OKAY, "same enable");
        // Stack pointer: low byte held, interrupts blocked
        expectWrite(A_SPL, 8'h34, 3, RESP_OKAY, "sp low");
        check(irqEnable, 1'b0, "sp hold");
        check(stackPointer, TOP, "sp not yet");
        repeat (3) cpuOp(2'h0);
        check(irqEnable, 1'b0, "sp hold 3");
        cpuOp(2'h0);
        check(irqEnable, 1'b1, "sp hold over");
        expectWrite(A_SPH, 8'h12, 3, RESP_OKAY, "sp high");
        check(stackPointer, 16'h1234, "sp commit");
        expectWrite(A_SPL, 8'h00, 3, RESP_OKAY, "sp low 2");
        cpuOp(2'h1);
        check(irqEnable, 1'b1, "hold ended by write");
        expectWrite(A_SPH, 8'hFF, 3, RESP_OKAY, "sp high 2");
        check(stackPointer, 16'h3F00, "sp width");
        expectRead(A_SPL, 32'h0000_0000, RESP_OKAY, "sp low rd");
        expectRead(A_SPH, 32'h0000_003F, RESP_OKAY, "sp high rd");
        $display("test stack pointer done");
        // I/O window: full length, then each cancelling event
        for (int k = 0; k < 5; k++)
        begin
            expectWrite(A_KEY, KEY_IO, 3, RESP_OKAY, "io key");
            check(ioUnlock, 1'b1, "io open");
            check(irqEnable, 1'b0, "irq held io");
            expectRead(A_KEY, 32'h0000_0001, RESP_OKAY, "io readback");
            if (k == 0)
                repeat (3) cpuOp(2'h0);
            check(ioUnlock, 1'b1, "io still open");
            if (k == 4)
                expectWrite(A_FLG, 8'h80, 3, RESP_OKAY, "protected write");
            else
                cpuOp(2'(k));
            check(ioUnlock, 1'b0, "io closed");
            check(irqEnable, 1'b1, "irq back");
            expectRead(A_KEY, 32'h0000_0000, RESP_OKAY, "io cleared");
        end
        // Self-program window: memory write keeps it, nonvolatile and sleep end it
        for (int k = 1; k < 4; k++)
        begin
            expectWrite(A_KEY, KEY_SPM, 3, RESP_OKAY, "spm key");
            check(selfProgramUnlock, 1'b1, "spm open");
            check(irqEnable, 1'b0, "irq held spm");
            expectRead(A_KEY, 32'h0000_0002, RESP_OKAY, "spm readback");
            cpuOp(2'(k));
            check(selfProgramUnlock, k == 1, "spm after event");
        end
        expectWrite(A_KEY, 8'hFF, 3, RESP_OKAY, "other key");
        expectRead(A_KEY, 32'h0000_0000, RESP_OKAY, "no window");
        $display("test unlock windows done");
        // Flags: sign, bit copy, enable set and clear
        expectWrite(A_FLG, 8'h00, 4, RESP_OKAY, "flags clear");
        pulseFlags({1'b1, 8'h0C, 8'h04}, '0);
        check(statusFlags, 8'h14, "sign n");
        pulseFlags({1'b1, 8'h08, 8'h08}, '0);
        check(statusFlags, 8'h0C, "sign n v");
        expectWrite(A_FLG, 8'h10, 3, RESP_OKAY, "sign write");
        expectRead(A_FLG, 32'h0000_0000, RESP_OKAY, "sign forced");
        pulseFlags('0, 4'b1100);
        check({bitLoadValue, statusFlags}, 9'h140, "bit store 1");
        pulseFlags('0, 4'b1000);
        check(bitLoadValue, 1'b0, "bit store 0");
        pulseFlags('0, 4'b0010);
        pulseFlags({1'b1, 8'h7F, 8'h00}, '0);
        check(statusFlags, 8'h80, "enable kept");
        pulseFlags('0, 4'b0001);
        check({irqEnable, statusFlags}, 9'h000, "enable cleared");
        $display("test status flags done");
        results();
    end
endmodule // testbench
